/* File: fpu_cmov_compare_decode.sv */
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// RQ1: DA 11-001-n moves ST(n) to top if ZF
// RQ2: DA 11-010-n moves if CF or ZF
// RQ3: DA 11-011-n moves if PF set
// RQ4: DB 11-000-n moves if CF clear
// RQ5: DB 11-001-n moves if ZF clear
// RQ6: DB 11-010-n moves if CF, ZF clear
// RQ7: DB 11-011-n moves if PF clear
// RQ8: D8 11-010-n compares top, ST(n), no pop
// RQ9: DC/D8 memory reg 010 compare real
// RQ10: D8 11-011-n compare then pop once
// RQ11: DC/D8 memory reg 011 compare, pop
// RQ12: DE D9 compares top, ST(1), pops twice
// RQ13: DB 11-110-n compare into integer flags
// RQ14: DF 11-110-n integer flags compare, pop
// RQ15: DB 11-101-n unordered flags compare, 9 clocks
// RQ16: DF 11-101-n unordered flags compare, pop
// RQ17: DA memory reg 010 integer compare
// RQ18: DE memory reg 010 integer compare
// RQ19: DA/DE memory reg 011 compare, pop
// RQ20: D9 FF cosine of top, 92-141 clocks
// RQ21: DA 11-000-n moves if CF set
// RQ22: Top register chosen by stack-top pointer
// RQ23: Four-entry instruction queue from integer unit
// RQ24: Pop empties top, pointer advances modulo eight
// RQ25: Unordered result code; ordered forms flag invalid
module fpu_cmov_compare_decode #(
  parameter int QDEPTH = 4,
  parameter int ADR_W  = 8
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ADR_W-1:0]         wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     instr_valid_i,
  output logic                          instr_ready_o,
  input  wire logic [7:0]               instr_opcode_i,
  input  wire logic [7:0]               instr_modrm_i,
  input  wire logic [fpu_pkg::FP_W-1:0] instr_mem_op_i,
  input  wire logic                     flag_cf_i,
  input  wire logic                     flag_zf_i,
  input  wire logic                     flag_pf_i,
  output logic      [2:0]               int_flags_o,
  output logic                          int_flags_we_o,
  output logic      [fpu_pkg::FP_W-1:0] cos_arg_o,
  input  wire logic [fpu_pkg::FP_W-1:0] cos_result_i,
  output logic                          busy_o
);
  import fpu_pkg::*;

  localparam int QW = $clog2(QDEPTH);

  // ****************************************
  // Instruction queue
  // ****************************************
  logic [7:0]      q_opc_reg [QDEPTH];
  logic [7:0]      q_modrm_reg [QDEPTH];
  logic [FP_W-1:0] q_mem_reg [QDEPTH];
  logic [QW-1:0]   q_wr_reg;
  logic [QW-1:0]   q_rd_reg;
  logic [QW:0]     q_cnt_reg;
  logic            enq;
  logic            deq;
  exec_state_t     state_reg;

  assign instr_ready_o = (q_cnt_reg != QDEPTH[QW:0]);
  assign enq = instr_valid_i && instr_ready_o;
  assign deq = (state_reg == ST_IDLE) && (q_cnt_reg != '0);

  // Queue storage; integer unit keeps running while slots remain
  always_ff @(posedge clk_i) begin
    if (enq) begin
      q_opc_reg[q_wr_reg]   <= instr_opcode_i;  // [RQ23]
      q_modrm_reg[q_wr_reg] <= instr_modrm_i;
      q_mem_reg[q_wr_reg]   <= instr_mem_op_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_wr_reg  <= '0;
      q_rd_reg  <= '0;
      q_cnt_reg <= '0;
    end else begin
      if (enq) begin
        q_wr_reg <= (q_wr_reg == QW'(QDEPTH - 1)) ? '0 : q_wr_reg + 1'b1;
      end
      if (deq) begin
        q_rd_reg <= (q_rd_reg == QW'(QDEPTH - 1)) ? '0 : q_rd_reg + 1'b1;
      end
      q_cnt_reg <= q_cnt_reg + (QW+1)'(enq) - (QW+1)'(deq);  // [RQ23]
    end
  end

  // ****************************************
  // Register stack
  // ****************************************
  logic [FP_W-1:0] stk_reg [NSTK];
  logic [7:0]      tag_reg;
  logic [2:0]      top_reg;
  logic [FP_W-1:0] stack_top_register;
  logic [7:0]      opc;
  logic [7:0]      modrm;
  logic [2:0]      rf;
  logic            is_reg;
  logic [2:0]      src_idx;

  assign stack_top_register     = stk_reg[top_reg];  // [RQ22]
  assign opc     = q_opc_reg[q_rd_reg];
  assign modrm   = q_modrm_reg[q_rd_reg];
  assign rf      = modrm[5:3];
  assign is_reg  = (modrm[7:6] == MOD_REG);
  // ST(n) is relative to the top pointer; wraps modulo eight
  assign src_idx = top_reg + ((opc == OPC_DE) ? 3'd1 : modrm[2:0]);  // [RQ22]

  // ****************************************
  // Decode of queue head
  // ****************************************
  op_kind_t   d_kind;
  logic [7:0] d_lat;
  logic [1:0] d_pops;
  logic       d_unord;
  logic       d_use_reg;

  // Unlisted encodings fall through as OP_NONE and are dropped
  always_comb begin
    d_kind    = OP_NONE;
    d_lat     = LAT_SHORT;
    d_pops    = 2'd0;
    d_unord   = 1'b0;
    d_use_reg = is_reg;
    unique case (opc)
      OPC_DA: begin
        if (is_reg && !rf[2]) begin
          d_kind = OP_MOVE;  // [RQ21] [RQ1] [RQ2] [RQ3]
        end else if (!is_reg && rf[2:1] == RF_CMP_HI) begin
          d_kind = OP_CMP_CC;  // [RQ17] [RQ19]
          d_lat  = LAT_INT;
          d_pops = {1'b0, rf[0]};
        end
      end
      OPC_DB: begin
        if (is_reg && !rf[2]) begin
          d_kind = OP_MOVE;  // [RQ4] [RQ5] [RQ6] [RQ7]
        end else if (is_reg && rf == RF_UCMI) begin
          d_kind  = OP_CMP_IF;  // [RQ15]
          d_lat   = LAT_INT;
          d_unord = 1'b1;
        end else if (is_reg && rf == RF_CMI) begin
          d_kind = OP_CMP_IF;  // [RQ13]
        end
      end
      OPC_D8, OPC_DC: begin
        if (rf[2:1] == RF_CMP_HI && (opc == OPC_D8 || !is_reg)) begin
          d_kind = OP_CMP_CC;  // [RQ8] [RQ9] [RQ10] [RQ11]
          d_pops = {1'b0, rf[0]};
        end
      end
      OPC_DE: begin
        if (modrm == MODRM_CPP) begin
          d_kind = OP_CMP_CC;  // [RQ12]
          d_pops = 2'd2;
        end else if (!is_reg && rf[2:1] == RF_CMP_HI) begin
          d_kind = OP_CMP_CC;  // [RQ18] [RQ19]
          d_lat  = LAT_INT;
          d_pops = {1'b0, rf[0]};
        end
      end
      OPC_DF: begin
        if (is_reg && (rf == RF_UCMI || rf == RF_CMI)) begin
          d_kind  = OP_CMP_IF;  // [RQ14] [RQ16]
          d_unord = (rf == RF_UCMI);
          d_lat   = (rf == RF_UCMI) ? LAT_INT : LAT_SHORT;
          d_pops  = 2'd1;
        end
      end
      OPC_D9: begin
        if (modrm == MODRM_COS) begin
          d_kind = OP_COS;
          // Large arguments need reduction first, hence the longer count
          d_lat  = (stack_top_register[EXP_MSB:EXP_LSB] < EXP_ONE) ? LAT_COS_LO : LAT_COS_HI;  // [RQ20]
        end
      end
      default: begin
        d_kind = OP_NONE;
      end
    endcase
  end

  // ****************************************
  // Execution sequencer
  // ****************************************
  op_kind_t        ex_kind_reg;
  logic [1:0]      ex_pops_reg;
  logic            ex_unord_reg;
  logic [2:0]      ex_cond_reg;
  logic [FP_W-1:0] ex_opnd_reg;
  logic [7:0]      ex_cnt_reg;
  logic            start;
  logic            commit;

  assign start  = deq && (d_kind != OP_NONE);
  assign commit = (state_reg == ST_RUN) && (ex_cnt_reg == '0);
  assign busy_o = (state_reg == ST_RUN);

  // One op at a time; operand captured at issue so stack is stable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      ex_kind_reg  <= OP_NONE;
      ex_pops_reg  <= 2'd0;
      ex_unord_reg <= 1'b0;
      ex_cond_reg  <= 3'd0;
      ex_opnd_reg  <= '0;
      ex_cnt_reg   <= '0;
      cos_arg_o    <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg    <= ST_RUN;
            ex_kind_reg  <= d_kind;
            ex_pops_reg  <= d_pops;
            ex_unord_reg <= d_unord;
            ex_cond_reg  <= {opc[0], rf[1:0]};
            ex_opnd_reg  <= d_use_reg ? stk_reg[src_idx] : q_mem_reg[q_rd_reg];
            ex_cnt_reg   <= d_lat - 8'd2;  // [RQ20]
            cos_arg_o    <= stack_top_register;
          end
        end
        ST_RUN: begin
          if (ex_cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            ex_cnt_reg <= ex_cnt_reg - 8'd1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Compare and move condition
  // ****************************************
  function automatic logic is_nan(input logic [FP_W-1:0] x);
    return (&x[EXP_MSB:EXP_LSB]) && (|x[QNAN_BIT:0]);
  endfunction

  function automatic logic is_snan(input logic [FP_W-1:0] x);
    return is_nan(x) && !x[QNAN_BIT];
  endfunction

  // Sign-magnitude order; both zeros equal regardless of sign
  function automatic logic [2:0] fcmp(input logic [FP_W-1:0] a, input logic [FP_W-1:0] b);
    logic gt;
    gt = 1'b0;
    if (is_nan(a) || is_nan(b)) begin
      return CMP_UN;
    end
    if (a[EXP_MSB:0] == '0 && b[EXP_MSB:0] == '0) begin
      return CMP_EQ;
    end
    if (a == b) begin
      return CMP_EQ;
    end
    if (a[FP_W-1] != b[FP_W-1]) begin
      gt = b[FP_W-1];
    end else begin
      gt = (a[EXP_MSB:0] > b[EXP_MSB:0]) ^ a[FP_W-1];
    end
    return gt ? CMP_GT : CMP_LT;
  endfunction

  logic [2:0] cmp_code;
  logic       move_base;
  logic       move_ok;
  logic       cmp_inv;

  assign cmp_code = fcmp(stack_top_register, ex_opnd_reg);  // [RQ25]

  // Low two reg bits pick the flag test; opcode bit 0 inverts it
  always_comb begin
    unique case (ex_cond_reg[1:0])
      2'd0: move_base = flag_cf_i;  // [RQ21] [RQ4]
      2'd1: move_base = flag_zf_i;  // [RQ1] [RQ5]
      2'd2: move_base = flag_cf_i | flag_zf_i;  // [RQ2] [RQ6]
      2'd3: move_base = flag_pf_i;  // [RQ3] [RQ7]
    endcase
  end
  assign move_ok = move_base ^ ex_cond_reg[2];

  // Unordered forms only trap signalling NaNs
  assign cmp_inv = commit && (ex_kind_reg == OP_CMP_CC || ex_kind_reg == OP_CMP_IF) &&
                   (ex_unord_reg ? (is_snan(stack_top_register) || is_snan(ex_opnd_reg))
                                 : (is_nan(stack_top_register) || is_nan(ex_opnd_reg)));  // [RQ25]

  // ****************************************
  // Register bus slave
  // ****************************************
  logic        wb_wr;
  logic [31:0] wmask;
  logic [2:0]  sel_idx_reg;
  logic [1:0]  sel_word_reg;
  logic        ie_reg;
  logic [2:0]  cc_reg;
  logic        idle_wr;

  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign idle_wr = wb_wr && (state_reg == ST_IDLE);

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data latched with the ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= '0;
      unique case (wb_adr_i)
        ADR_STATUS: begin
          wb_dat_o[ST_IE_BIT]                 <= ie_reg;
          wb_dat_o[ST_QCNT_LSB+QW:ST_QCNT_LSB] <= q_cnt_reg;
          wb_dat_o[ST_C0_BIT]                 <= cc_reg[0];
          wb_dat_o[ST_C2_BIT]                 <= cc_reg[1];
          wb_dat_o[ST_TOP_LSB+2:ST_TOP_LSB]   <= top_reg;
          wb_dat_o[ST_C3_BIT]                 <= cc_reg[2];
          wb_dat_o[ST_BUSY_BIT]               <= busy_o;
        end
        ADR_TAG:  wb_dat_o[7:0] <= tag_reg;
        ADR_SEL:  wb_dat_o[5:0] <= {sel_word_reg, 1'b0, sel_idx_reg};
        ADR_DATA: begin
          unique case (sel_word_reg)
            2'd0:    wb_dat_o <= stk_reg[sel_idx_reg][31:0];
            2'd1:    wb_dat_o <= stk_reg[sel_idx_reg][63:32];
            default: wb_dat_o[15:0] <= stk_reg[sel_idx_reg][79:64];
          endcase
        end
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // Stack window selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_idx_reg  <= '0;
      sel_word_reg <= '0;
    end else if (wb_wr && wb_adr_i == ADR_SEL && wb_sel_i[0]) begin
      sel_idx_reg  <= wb_dat_i[2:0];
      sel_word_reg <= wb_dat_i[SEL_WORD_LSB+1:SEL_WORD_LSB];
    end
  end

  // ****************************************
  // Stack update: software load, then commit
  // ****************************************
  logic [FP_W-1:0] sw_word;

  // Software may touch the stack only between instructions
  always_comb begin
    sw_word = stk_reg[sel_idx_reg];
    unique case (sel_word_reg)
      2'd0:    sw_word[31:0]  = (sw_word[31:0] & ~wmask) | (wb_dat_i & wmask);
      2'd1:    sw_word[63:32] = (sw_word[63:32] & ~wmask) | (wb_dat_i & wmask);
      default: sw_word[79:64] = (sw_word[79:64] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSTK; i++) begin
        stk_reg[i] <= '0;
      end
      tag_reg <= TAG_RST;
      top_reg <= 3'd0;
    end else begin
      if (idle_wr && wb_adr_i == ADR_DATA) begin
        stk_reg[sel_idx_reg] <= sw_word;
        tag_reg[sel_idx_reg] <= 1'b0;
      end
      if (idle_wr && wb_adr_i == ADR_TAG && wb_sel_i[0]) begin
        tag_reg <= wb_dat_i[7:0];
      end
      if (idle_wr && wb_adr_i == ADR_STATUS && wb_sel_i[1]) begin
        top_reg <= wb_dat_i[ST_TOP_LSB+2:ST_TOP_LSB];
      end
      if (commit && ex_kind_reg == OP_MOVE && move_ok) begin
        stk_reg[top_reg] <= ex_opnd_reg;  // [RQ1] [RQ4] [RQ22]
        tag_reg[top_reg] <= 1'b0;
      end
      if (commit && ex_kind_reg == OP_COS) begin
        stk_reg[top_reg] <= cos_result_i;  // [RQ20]
      end
      if (commit && ex_pops_reg != 2'd0) begin
        tag_reg[top_reg] <= 1'b1;  // [RQ24]
        top_reg <= top_reg + {1'b0, ex_pops_reg};  // [RQ10] [RQ12]
        if (ex_pops_reg == 2'd2) begin
          tag_reg[top_reg + 3'd1] <= 1'b1;  // [RQ12]
        end
      end
    end
  end

  // Condition code, sticky invalid flag (write 1 clears, set wins)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_reg <= 3'd0;
      ie_reg <= 1'b0;
    end else begin
      if (commit && ex_kind_reg == OP_CMP_CC) begin
        cc_reg <= cmp_code;  // [RQ8] [RQ9] [RQ17] [RQ18]
      end
      ie_reg <= cmp_inv || (ie_reg && !(wb_wr && wb_adr_i == ADR_STATUS &&
                                        wb_sel_i[0] && wb_dat_i[ST_IE_BIT]));
    end
  end

  // Integer flags result, strobed for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_flags_o    <= 3'd0;
      int_flags_we_o <= 1'b0;
    end else begin
      int_flags_we_o <= commit && ex_kind_reg == OP_CMP_IF;  // [RQ13] [RQ14]
      if (commit && ex_kind_reg == OP_CMP_IF) begin
        int_flags_o <= cmp_code;  // [RQ15] [RQ16]
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_start_short;
    start && d_lat == LAT_SHORT;
  endsequence
  sequence s_start_int;
    start && d_lat == LAT_INT;
  endsequence

  property p_queue_full;
    @(posedge clk_i) disable iff (rst_i)
      (q_cnt_reg == QDEPTH[QW:0]) |-> !instr_ready_o;
  endproperty
  a_queue_full: assert property (p_queue_full) else $error("queue full but ready");  // [RQ23]

  property p_short_lat;
    @(posedge clk_i) disable iff (rst_i)
      s_start_short |-> (!commit) [*3] ##1 commit;
  endproperty
  a_short_lat: assert property (p_short_lat) else $error("4-clock op mistimed");  // [RQ8]

  property p_int_lat;
    @(posedge clk_i) disable iff (rst_i)
      s_start_int |-> ##8 commit;
  endproperty
  a_int_lat: assert property (p_int_lat) else $error("9-clock op mistimed");  // [RQ15]

  property p_cos_lat;
    @(posedge clk_i) disable iff (rst_i)
      (start && d_kind == OP_COS) |-> ##[91:140] commit;
  endproperty
  a_cos_lat: assert property (p_cos_lat) else $error("cosine count out of range");  // [RQ20]

  property p_pop_one;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_pops_reg == 2'd1) |=>
        top_reg == $past(top_reg) + 3'd1 && tag_reg[$past(top_reg)];
  endproperty
  a_pop_one: assert property (p_pop_one) else $error("single pop wrong");  // [RQ24]

  property p_pop_two;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_pops_reg == 2'd2) |=> top_reg == $past(top_reg) + 3'd2;
  endproperty
  a_pop_two: assert property (p_pop_two) else $error("double pop wrong");  // [RQ12]

  property p_move_taken;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_kind_reg == OP_MOVE && move_ok) |=> stack_top_register == $past(ex_opnd_reg);
  endproperty
  a_move_taken: assert property (p_move_taken) else $error("move not done");  // [RQ1]

  property p_move_skip;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_kind_reg == OP_MOVE && !move_ok && !wb_wr) |=> $stable(stack_top_register);
  endproperty
  a_move_skip: assert property (p_move_skip) else $error("move done wrongly");  // [RQ4]

  property p_iflags;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_kind_reg == OP_CMP_IF) |=> int_flags_we_o && int_flags_o == $past(cmp_code);
  endproperty
  a_iflags: assert property (p_iflags) else $error("integer flags not written");  // [RQ13]

  property p_unord_cc;
    @(posedge clk_i) disable iff (rst_i)
      (commit && ex_kind_reg == OP_CMP_CC && is_nan(stack_top_register)) |=> cc_reg == CMP_UN && ie_reg;
  endproperty
  a_unord_cc: assert property (p_unord_cc) else $error("unordered code missing");  // [RQ25]

endmodule

/* File: fpu_pkg.sv */
package fpu_pkg;

  // ****************************************
  // Data format and stack
  // ****************************************
  localparam int          FP_W      = 80;
  localparam int          NSTK      = 8;
  localparam int          EXP_MSB   = 78;
  localparam int          EXP_LSB   = 64;
  localparam int          QNAN_BIT  = 62;
  localparam logic [14:0] EXP_ONE   = 15'h3FFF;

  // ****************************************
  // Opcode bytes and ModRM fields
  // ****************************************
  localparam logic [7:0] OPC_D8     = 8'hD8;
  localparam logic [7:0] OPC_D9     = 8'hD9;
  localparam logic [7:0] OPC_DA     = 8'hDA;
  localparam logic [7:0] OPC_DB     = 8'hDB;
  localparam logic [7:0] OPC_DC     = 8'hDC;
  localparam logic [7:0] OPC_DE     = 8'hDE;
  localparam logic [7:0] OPC_DF     = 8'hDF;
  localparam logic [7:0] MODRM_CPP  = 8'hD9;
  localparam logic [7:0] MODRM_COS  = 8'hFF;
  localparam logic [1:0] MOD_REG    = 2'b11;
  localparam logic [1:0] RF_CMP_HI  = 2'b01;
  localparam logic [2:0] RF_UCMI    = 3'b101;
  localparam logic [2:0] RF_CMI     = 3'b110;

  // ****************************************
  // Clock counts
  // ****************************************
  localparam logic [7:0] LAT_SHORT  = 8'h04;
  localparam logic [7:0] LAT_INT    = 8'h09;
  localparam logic [7:0] LAT_COS_LO = 8'h5C;
  localparam logic [7:0] LAT_COS_HI = 8'h8D;

  // ****************************************
  // Compare result codes {c3,c2,c0} = {zf,pf,cf}
  // ****************************************
  localparam logic [2:0] CMP_GT = 3'b000;
  localparam logic [2:0] CMP_LT = 3'b001;
  localparam logic [2:0] CMP_EQ = 3'b100;
  localparam logic [2:0] CMP_UN = 3'b111;

  // ****************************************
  // Register map and status fields
  // ****************************************
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_TAG    = 8'h04;
  localparam logic [7:0] ADR_SEL    = 8'h08;
  localparam logic [7:0] ADR_DATA   = 8'h0C;
  localparam int ST_IE_BIT   = 0;
  localparam int ST_QCNT_LSB = 4;
  localparam int ST_C0_BIT   = 8;
  localparam int ST_C2_BIT   = 10;
  localparam int ST_TOP_LSB  = 11;
  localparam int ST_C3_BIT   = 14;
  localparam int ST_BUSY_BIT = 15;
  localparam int SEL_WORD_LSB = 4;
  localparam logic [7:0] TAG_RST = 8'hFF;

  typedef enum logic [2:0] {
    OP_NONE = 3'd0, OP_MOVE = 3'd1, OP_CMP_CC = 3'd2, OP_CMP_IF = 3'd3, OP_COS = 3'd4
  } op_kind_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} exec_state_t;

endpackage

/* File: int_unit_model.sv */
`timescale 1ns/1ps
// ****
// Integer unit stand-in
// ****
module int_unit_model (
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic [79:0] cos_arg_i,
  output logic             valid_o,
  output logic [7:0]       opcode_o,
  output logic [7:0]       modrm_o,
  output logic [79:0]      mem_op_o,
  output logic [79:0]      cos_result_o
);
  // Trig stand-in: inverted argument, so every bit is predictable
  assign cos_result_o = ~cos_arg_i;

  initial begin
    valid_o  = 1'b0;
    opcode_o = 8'h00;
    modrm_o  = 8'h00;
    mem_op_o = '0;
  end

  // Offer one op; hold it until the queue takes it
  task automatic issue(input logic [7:0] op, input logic [7:0] mr, input logic [79:0] m);
    @(posedge clk_i);
    valid_o  <= 1'b1;
    opcode_o <= op;
    modrm_o  <= mr;
    mem_op_o <= m;
    @(posedge clk_i);
    for (int i = 0; i < 50 && !ready_i; i++) @(posedge clk_i);
    valid_o  <= 1'b0;
    mem_op_o <= ~m;  // Stale operand no longer shown
  endtask
endmodule

/* File: fpu_cmov_compare_decode_tb.sv */
`timescale 1ns/1ps
module fpu_cmov_compare_decode_tb;
  import fpu_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        cf = 1'b0, zf = 1'b0, pf = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o, rd;
  logic        ack, valid, ready, busy, ifwe;
  int          nwe = 0;
  logic [7:0]  opc, mrm;
  logic [79:0] mem, carg, cres;
  logic [2:0]  iflags;
  logic [31:0] v [8];
  logic [15:0] mtab [8] = '{16'hDAC8, 16'hDAD0, 16'hDAD8, 16'hDBC0,
                            16'hDBC8, 16'hDBD0, 16'hDBD8, 16'hDAC0};
  logic [7:0]  ctab [4] = '{8'hD8, 8'hD8, 8'hDA, 8'hDE};
  int          bad_count = 0;
  int          n_compared = 0;
  int          n, k;
  logic [31:0] m, b;

  fpu_cmov_compare_decode u_fpu_cmov_compare_decode (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .instr_valid_i(valid), .instr_ready_o(ready), .instr_opcode_i(opc),
    .instr_modrm_i(mrm), .instr_mem_op_i(mem), .flag_cf_i(cf), .flag_zf_i(zf),
    .flag_pf_i(pf), .int_flags_o(iflags), .int_flags_we_o(ifwe), .cos_arg_o(carg),
    .cos_result_i(cres), .busy_o(busy));

  int_unit_model u_int_unit_model (
    .clk_i(clk_i), .ready_i(ready), .cos_arg_i(carg), .valid_o(valid),
    .opcode_o(opc), .modrm_o(mrm), .mem_op_o(mem), .cos_result_o(cres));

  always #2.5 clk_i = ~clk_i;

  // Count integer-flag write strobes; one per flag compare expected
  always @(posedge clk_i) begin
    if (ifwe === 1'b1) nwe++;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Classic single cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    for (int i = 0; i < 20 && !ack; i++) @(posedge clk_i);
    if (ack !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Issue one op and wait for the sequencer to go idle
  task automatic run(input logic [7:0] op, input logic [7:0] mr, input logic [31:0] mv);
    u_int_unit_model.issue(op, mr, {48'h0, mv});
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0) begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic rdreg(input logic [2:0] r);
    wb(1'b1, ADR_SEL, {29'h0, r});
    wb(1'b0, ADR_DATA, 32'h0000_0000);
  endtask

  function automatic logic [2:0] cmpx(input logic [31:0] a, input logic [31:0] c);
    return (a == c) ? CMP_EQ : ((a < c) ? CMP_LT : CMP_GT);
  endfunction

  // Flag condition of each move encoding, in table order
  function automatic logic mvc(input int i);
    case (i)
      0: return zf;
      1: return cf | zf;
      2: return pf;
      3: return !cf;
      4: return !zf;
      5: return !cf && !zf;
      6: return !pf;
      default: return cf;
    endcase
  endfunction

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'hdcdb));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b0, ADR_TAG, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Small values so equal operands turn up often
    for (int i = 0; i < 8; i++) begin
      v[i] = $urandom % 8;
      wb(1'b1, ADR_SEL, i);
      wb(1'b1, ADR_DATA, v[i]);
    end
    for (int r = 0; r < 16; r++) begin
      k = r % 8;
      n = 1 + $urandom % 7;
      {cf, zf, pf} <= 3'($urandom);
      run(mtab[k][15:8], mtab[k][7:0] | 8'(n), 32'h0);
      if (mvc(k)) v[0] = v[n];
      rdreg(3'd0);
      chk(rd, v[0]);
    end
    for (int r = 0; r < 12; r++) begin
      k = r % 4;
      n = $urandom % 8;
      m = $urandom % 8;
      b = (k == 0) ? v[n] : m;
      run(ctab[k], (k == 0) ? (8'hD0 | 8'(n)) : 8'h10, m);
      wb(1'b0, ADR_STATUS, 32'h0000_0000);
      chk({rd[14], rd[10], rd[8]}, cmpx(v[0], b));
      run(OPC_DB, (r[0] ? 8'hE8 : 8'hF0) | 8'(n), 32'h0);
      chk(iflags, cmpx(v[0], v[n]));
    end
    run(OPC_D8, 8'hD9, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(rd[13:11], 3'd1);
    run(OPC_DE, MODRM_CPP, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(rd[13:11], 3'd3);
    run(OPC_DF, 8'hF0, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(rd[13:11], 3'd4);
    wb(1'b0, ADR_TAG, 32'h0000_0000);
    chk(rd, 32'h0000_000F);
    run(OPC_D9, MODRM_COS, 32'h0);
    rdreg(3'd4);
    chk(rd, ~v[4]);
    chk(nwe, 32'd13);
    // Inverted top now has all-ones exponent: a quiet NaN
    run(OPC_D8, 8'hD0, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk({rd[14], rd[10], rd[8]}, CMP_UN);
    chk(rd[0], 1'b1);
    wb(1'b1, ADR_STATUS, 32'h0000_2001);
    wb(1'b0, ADR_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b0);
    chk(rd[13:11], 3'd4);
    print_verdict();
  end
endmodule
